// *** hdl/sacc_pkg.sv ***
// Package of constants and carrier types for the converter control block.
package sacc_pkg;

   // Register byte offsets on the bus.
   localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_STATUS2        = 8'h04;
   localparam logic [7:0] OFS_RESULT_HIGH    = 8'h08;
   localparam logic [7:0] OFS_RESULT_LOW     = 8'h0c;
   localparam logic [7:0] OFS_COMPARE        = 8'h10;
   localparam logic [7:0] OFS_CONFIG         = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS     = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK       = 8'h1c;
   localparam logic [7:0] OFS_POWER_MGMT     = 8'h20;

   // Field positions in the status and control register.
   localparam int BIT_DONE       = 7;
   localparam int BIT_IRQ_EN     = 6;
   localparam int BIT_CONTINUOUS = 5;
   // Field positions in the second status register.
   localparam int BIT_ACTIVE     = 7;
   localparam int BIT_TRIG_SEL   = 6;
   localparam int BIT_CMP_EN     = 5;
   localparam int BIT_CMP_GE     = 4;
   // Configuration register fields.
   localparam int BIT_MODE10     = 0;
   localparam int BIT_RATE_LO    = 4;
   localparam int BIT_WAKE_CLK   = 7;
   // Power management fields.
   localparam int BIT_LV_DETECT  = 0;
   localparam int BIT_LV_STOP    = 1;
   // Interrupt status bits.
   localparam int IRQ_DONE       = 0;
   localparam int IRQ_HW_TRIG    = 1;

   // Channel codes.
   localparam logic [4:0] CH_DISABLED  = 5'h1f;
   localparam logic [4:0] CH_LOW_REF   = 5'h1e;
   localparam logic [4:0] CH_HIGH_REF  = 5'h1d;
   localparam logic [4:0] CH_RESERVED  = 5'h1c;
   localparam logic [4:0] CH_LAST_PIN  = 5'h1b;

   // Reset values.
   localparam logic [7:0] RST_STATUS_CONTROL = 8'h1f;

   // Internal wake counter source: nominal 1 kHz derived from 250 MHz.
   localparam int CLK_MHZ        = 250;
   localparam int SLOW_HZ        = 1000;
   localparam int SLOW_DIV       = (CLK_MHZ * 1000000) / SLOW_HZ;
   // Successive approximation step count for a 10-bit result.
   localparam logic [3:0] SAR_STEPS = 4'ha;

   // Conversion state machine.
   typedef enum logic [1:0] {
      SACC_IDLE   = 2'b00,
      SACC_CONV   = 2'b01,
      SACC_FINISH = 2'b10
   } sacc_state_t;

   // Analog core request carrier.
   typedef struct packed {
      logic       power_on;
      logic       sample;
      logic [4:0] channel;
      logic [9:0] trial;
   } sacc_core_t;

endpackage

// *** hdl/sacc_ctrl.sv ***
// Conversion control logic for a 10-bit successive-approximation converter.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module sacc_ctrl (
   // Clock and reset.
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   // AHB-Lite slave.
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // External reference clock level and stop-mode request, both asynchronous.
   input  wire logic        ext_reference_clock_in,
   input  wire logic        retained_stop_mode_in,
   // Analog core comparator answer.
   input  wire logic        core_compare_in,
   // Analog core controls.
   output var sacc_pkg::sacc_core_t core_out,
   output logic             conversion_active_out,
   // Interrupt.
   output logic             irq_out
);

   // Synchronised asynchronous inputs.
   logic [1:0] ext_sync;
   logic [1:0] stop_sync;
   logic       ext_prev;
   logic       ext_rise;
   logic       in_stop;

   // Software visible state.
   logic [7:0] ctl;
   logic [7:0] next_ctl;
   logic [3:0] sc2;
   logic [3:0] next_sc2;
   logic [9:0] result;
   logic [9:0] next_result;
   logic [9:0] cmp_value;
   logic [9:0] next_cmp_value;
   logic [7:0] cfg;
   logic [7:0] next_cfg;
   logic [1:0] pwr;
   logic [1:0] next_pwr;
   logic [1:0] irq_stat;
   logic [1:0] next_irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] next_irq_mask;

   // Bus data phase capture.
   logic       dp_write;
   logic       dp_read;
   logic [7:0] dp_addr;

   // Wake counter state.
   logic [17:0] slow_div;
   logic [17:0] next_slow_div;
   logic        slow_tick;
   logic [15:0] wake_cnt;
   logic [15:0] next_wake_cnt;
   logic        hw_conversion_trigger;

   // Conversion engine state.
   sacc_pkg::sacc_state_t state;
   sacc_pkg::sacc_state_t next_state;
   logic [3:0] step;
   logic [3:0] next_step;
   logic [9:0] trial;
   logic [9:0] next_trial;
   logic       armed;
   logic       next_armed;

   // Decoded events.
   logic       ctl_write;
   logic       low_read;
   logic       start_evt;
   logic       cmp_true;
   logic       allowed;
   logic [9:0] fmt_result;

   // Two-flip-flop synchronisers; the second stage alone feeds logic.
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ext_sync  <= 2'h0;
         stop_sync <= 2'h0;
         ext_prev  <= 1'b0;
      end else begin
         ext_sync  <= {ext_sync[0], ext_reference_clock_in};
         stop_sync <= {stop_sync[0], retained_stop_mode_in};
         ext_prev  <= ext_sync[1];
      end
   end

   assign ext_rise = ext_sync[1] & ~ext_prev;
   assign in_stop  = stop_sync[1];

   // Bus address phase is captured every cycle; the write and read flags mark accepted transfers.
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
         dp_addr  <= 8'h00;
      end else begin
         dp_write <= hsel_in & hready_in & htrans_in[1] & hwrite_in;
         dp_read  <= hsel_in & hready_in & htrans_in[1] & ~hwrite_in;
         dp_addr  <= haddr_in[7:0];
      end
   end

   // Zero wait states and always OKAY.
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;
   assign ctl_write = dp_write && dp_addr == sacc_pkg::OFS_STATUS_CONTROL;
   assign low_read  = dp_read && dp_addr == sacc_pkg::OFS_RESULT_LOW;

   // Read data is combinational from registers during the data phase.
   always_comb begin
      hrdata_out = 32'h0;
      if (dp_read) begin
         case (dp_addr)
            sacc_pkg::OFS_STATUS_CONTROL: hrdata_out = {24'h0, ctl};
            sacc_pkg::OFS_STATUS2:        hrdata_out = {24'h0, sc2, 4'h0};
            sacc_pkg::OFS_RESULT_HIGH:    hrdata_out = {30'h0, result[9:8]};
            sacc_pkg::OFS_RESULT_LOW:     hrdata_out = {24'h0, result[7:0]};
            sacc_pkg::OFS_COMPARE:        hrdata_out = {22'h0, cmp_value};
            sacc_pkg::OFS_CONFIG:         hrdata_out = {24'h0, cfg};
            sacc_pkg::OFS_IRQ_STATUS:     hrdata_out = {30'h0, irq_stat};
            sacc_pkg::OFS_IRQ_MASK:       hrdata_out = {30'h0, irq_mask};
            sacc_pkg::OFS_POWER_MGMT:     hrdata_out = {30'h0, pwr};
            default:                      hrdata_out = 32'h0;
         endcase
      end
   end

   // Free-running wake counter on either source; overflow is the trigger.
   always_comb begin
      next_slow_div = (slow_div == 18'(sacc_pkg::SLOW_DIV - 1)) ? 18'h0 : slow_div + 18'h1;
      slow_tick     = slow_div == 18'(sacc_pkg::SLOW_DIV - 1);
      next_wake_cnt = wake_cnt;
      hw_conversion_trigger = 1'b0;
      // The external reference only runs outside stop mode.
      if (cfg[sacc_pkg::BIT_WAKE_CLK] ? (ext_rise & ~in_stop) : slow_tick) begin
         // Rate select picks the overflow bit.
         next_wake_cnt = wake_cnt + 16'h1;
         hw_conversion_trigger = next_wake_cnt[cfg[sacc_pkg::BIT_RATE_LO +: 3] + 4'h8]
                                 & ~wake_cnt[cfg[sacc_pkg::BIT_RATE_LO +: 3] + 4'h8];
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         slow_div <= 18'h0;
         wake_cnt <= 16'h0;
      end else begin
         slow_div <= next_slow_div;
         wake_cnt <= next_wake_cnt;
      end
   end

   // Compare and result format.
   always_comb begin
      fmt_result = cfg[sacc_pkg::BIT_MODE10] ? trial : {2'h0, trial[9:2]};
      cmp_true = sc2[0] ? (fmt_result >= cmp_value) : (fmt_result < cmp_value);
      // Stop mode needs both low-voltage bits.
      allowed = ~in_stop | (pwr[sacc_pkg::BIT_LV_DETECT] & pwr[sacc_pkg::BIT_LV_STOP]);
      // Software start on write, hardware start on overflow.
      start_evt = sc2[2] ? hw_conversion_trigger : ctl_write;
   end

   // Conversion engine and register updates.
   always_comb begin
      next_state     = state;
      next_step      = step;
      next_trial     = trial;
      next_armed     = armed;
      next_ctl       = ctl;
      next_sc2       = sc2;
      next_result    = result;
      next_cmp_value = cmp_value;
      next_cfg       = cfg;
      next_pwr       = pwr;
      next_irq_stat  = irq_stat;
      next_irq_mask  = irq_mask;
      if (low_read) begin
         next_ctl[sacc_pkg::BIT_DONE] = 1'b0;
      end
      if (dp_write) begin
         case (dp_addr)
            sacc_pkg::OFS_STATUS_CONTROL: begin
               // Write aborts, clears done, and arms or powers down.
               next_ctl   = {1'b0, hwdata_in[6:0]};
               next_state = sacc_pkg::SACC_IDLE;
               next_armed = hwdata_in[4:0] != sacc_pkg::CH_DISABLED;
            end
            sacc_pkg::OFS_STATUS2:    next_sc2[2:0] = hwdata_in[6:4];
            sacc_pkg::OFS_COMPARE:    next_cmp_value = hwdata_in[9:0];
            sacc_pkg::OFS_CONFIG:     next_cfg = hwdata_in[7:0];
            sacc_pkg::OFS_IRQ_STATUS: next_irq_stat = irq_stat & ~hwdata_in[1:0];
            sacc_pkg::OFS_IRQ_MASK:   next_irq_mask = hwdata_in[1:0];
            sacc_pkg::OFS_POWER_MGMT: next_pwr = hwdata_in[1:0];
            default: begin
            end
         endcase
      end
      if (hw_conversion_trigger) begin
         next_irq_stat[sacc_pkg::IRQ_HW_TRIG] = 1'b1;
      end
      // A control write takes the idle path from any state, so an abort
      // in mid-conversion restarts at once in software-trigger mode instead of dropping the start.
      case (ctl_write ? sacc_pkg::SACC_IDLE : state)
         sacc_pkg::SACC_IDLE: begin
            // A write both aborts and may start in the same cycle.
            if (start_evt && (ctl_write ? hwdata_in[4:0] : ctl[4:0]) != sacc_pkg::CH_DISABLED
                && (sc2[2] ? armed : 1'b1) && allowed) begin
               next_state = sacc_pkg::SACC_CONV;
               next_step  = sacc_pkg::SAR_STEPS;
               next_trial = 10'h200;
            end
         end
         sacc_pkg::SACC_CONV: begin
            // One successive approximation bit per cycle.
            if (!ctl_write) begin
               next_trial = trial & ~(core_compare_in ? 10'h0 : (10'h1 << (step - 4'h1)));
               if (step > 4'h1) begin
                  next_trial = next_trial | (10'h1 << (step - 4'h2));
               end
               next_step = step - 4'h1;
               if (step == 4'h1) begin
                  next_state = sacc_pkg::SACC_FINISH;
               end
            end
         end
         sacc_pkg::SACC_FINISH: begin
            if (!ctl_write) begin
               if (!sc2[1] || cmp_true) begin
                  next_result = fmt_result;
                  next_ctl[sacc_pkg::BIT_DONE] = 1'b1;
                  next_irq_stat[sacc_pkg::IRQ_DONE] = 1'b1;
               end
               // Continuous runs again; single drops to low power.
               if (ctl[sacc_pkg::BIT_CONTINUOUS] && allowed) begin
                  next_state = sacc_pkg::SACC_CONV;
                  next_step  = sacc_pkg::SAR_STEPS;
                  next_trial = 10'h200;
               end else begin
                  next_state = sacc_pkg::SACC_IDLE;
               end
            end
         end
         default: next_state = sacc_pkg::SACC_IDLE;
      endcase
      // Active flag tracks a running conversion.
      next_sc2[3] = next_state != sacc_pkg::SACC_IDLE;
   end

   // State registers; reset leaves the converter disabled.
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state     <= sacc_pkg::SACC_IDLE;
         step      <= 4'h0;
         trial     <= 10'h0;
         armed     <= 1'b0;
         ctl       <= sacc_pkg::RST_STATUS_CONTROL;
         sc2       <= 4'h0;
         result    <= 10'h0;
         cmp_value <= 10'h0;
         cfg       <= 8'h00;
         pwr       <= 2'h0;
         irq_stat  <= 2'h0;
         irq_mask  <= 2'h0;
      end else begin
         state     <= next_state;
         step      <= next_step;
         trial     <= next_trial;
         armed     <= next_armed;
         ctl       <= next_ctl;
         sc2       <= next_sc2;
         result    <= next_result;
         cmp_value <= next_cmp_value;
         cfg       <= next_cfg;
         pwr       <= next_pwr;
         irq_stat  <= next_irq_stat;
         irq_mask  <= next_irq_mask;
      end
   end

   // Analog core controls; channel codes pass straight through.
   always_comb begin
      core_out.power_on = state != sacc_pkg::SACC_IDLE;
      core_out.sample   = state == sacc_pkg::SACC_CONV && step == sacc_pkg::SAR_STEPS;
      core_out.channel  = ctl[4:0];
      core_out.trial    = trial;
   end

   assign conversion_active_out = sc2[3];
   // Done interrupt only while the enable bit is set.
   assign irq_out = (irq_stat[sacc_pkg::IRQ_DONE] & irq_mask[sacc_pkg::IRQ_DONE]
                     & ctl[sacc_pkg::BIT_IRQ_EN])
                    | (irq_stat[sacc_pkg::IRQ_HW_TRIG] & irq_mask[sacc_pkg::IRQ_HW_TRIG]);

endmodule
`default_nettype wire

// *** verif/sacc_asserts.sv ***
// Port-level assertion checker for the converter control block.
`timescale 1ns/1ns
`default_nettype none
module sacc_asserts (
   // Clock, reset and bus.
   input wire logic                 sys_clk_in,
   input wire logic                 reset_in,
   input wire logic                 hsel_in,
   input wire logic [31:0]          haddr_in,
   input wire logic [1:0]           htrans_in,
   input wire logic                 hwrite_in,
   input wire logic [31:0]          hwdata_in,
   input wire logic                 hready_in,
   input wire logic [31:0]          hrdata_out,
   input wire logic                 hreadyout_out,
   input wire logic                 hresp_out,
   // Core side.
   input wire sacc_pkg::sacc_core_t core_out,
   input wire logic                 conversion_active_out
);
   logic       wr_now, rd_now, wr_pend, next_wr_pend;
   logic [4:0] last_ch, next_last_ch;
   // Tracks the control channel field as the bus last wrote it.
   always_comb begin
      rd_now = hsel_in && hready_in && htrans_in[1] && !hwrite_in
               && haddr_in[7:0] == sacc_pkg::OFS_STATUS_CONTROL;
      wr_now = hsel_in && hready_in && htrans_in[1] && hwrite_in
               && haddr_in[7:0] == sacc_pkg::OFS_STATUS_CONTROL;
      next_wr_pend = wr_now;
      next_last_ch = wr_pend ? hwdata_in[4:0] : last_ch;
   end
   // The channel starts disabled, as the register does.
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         wr_pend <= 1'b0;
         last_ch <= sacc_pkg::CH_DISABLED;
      end else begin
         wr_pend <= next_wr_pend;
         last_ch <= next_last_ch;
      end
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   // A control write whose data phase selects the disabled code.
   sequence off_wr_s;
      wr_now ##1 hwdata_in[4:0] == sacc_pkg::CH_DISABLED;
   endsequence
   // A conversion that ended and was not followed by another.
   sequence finish_s;
      $fell(conversion_active_out) ##1 (!conversion_active_out)[*3];
   endsequence
   active_off_a: assert property (off_wr_s |-> ##2 (!conversion_active_out)[*6])
      else $error("Conversion still active after a disabling write.");
   power_off_a: assert property (off_wr_s |-> ##3 (!core_out.power_on)[*5])
      else $error("Core still powered after a disabling write.");
   idle_power_a: assert property (finish_s |-> !core_out.power_on)
      else $error("Core left powered after a finished conversion.");
   active_power_a: assert property (conversion_active_out && $past(conversion_active_out)
      |-> core_out.power_on)
      else $error("Conversion active with the core powered down.");
   sample_power_a: assert property (core_out.sample |-> core_out.power_on)
      else $error("Sampling while the core is powered down.");
   channel_match_a: assert property (conversion_active_out && !$past(wr_pend)
      |-> core_out.channel == last_ch)
      else $error("Core channel differs from the written channel.");
   ctrl_read_a: assert property (rd_now ##1 1'b1 |-> hrdata_out[4:0] == last_ch)
      else $error("Channel field read back wrong.");
   bus_okay_a: assert property (hreadyout_out && !hresp_out)
      else $error("Bus response is not ready and okay.");
endmodule
bind sacc_ctrl sacc_asserts chk_u (
   .sys_clk_in(sys_clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
   .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
   .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
   .core_out(core_out), .conversion_active_out(conversion_active_out));
`default_nettype wire

// *** verif/sacc_core_model.sv ***
// Behavioural analog core: a comparator against a fixed level per channel.
`timescale 1ns/1ns
`default_nettype none
module sacc_core_model (
   // Clock and core controls.
   input  wire logic                 sys_clk_in,
   input  wire sacc_pkg::sacc_core_t core_in,
   // Comparator answer.
   output logic                      compare_out
);
   logic [9:0] level;
   logic       junk = 1'b0;
   // References sit at the rails, pins at a level coded from the channel.
   always_comb begin
      case (core_in.channel)
         sacc_pkg::CH_HIGH_REF: level = 10'h3ff;
         sacc_pkg::CH_LOW_REF:  level = 10'h000;
         default:               level = {core_in.channel, core_in.channel};
      endcase
   end
   // An unpowered core gives no valid answer, so it toggles instead.
   always_ff @(posedge sys_clk_in) junk <= ~junk;
   assign compare_out = core_in.power_on ? (level >= core_in.trial) : junk;
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic                 sys_clk_in = 1'b0, reset_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
   logic                 ext_ref = 1'b0, stop_mode = 1'b0, ext_run = 1'b0, rd_flag = 1'b0;
   logic [31:0]          haddr_in = 32'h0, hwdata_in = 32'h0, hrdata;
   logic [1:0]           htrans_in = 2'h0;
   logic                 hready, cmp, active, irq;
   sacc_pkg::sacc_core_t core;
   logic [31:0]          exp_q[$];
   int                   n_errors = 0, tests_run = 0, cycles = 0;
   // Device under test and its far-side comparator.
   sacc_ctrl dut_u (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
      .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
      .ext_reference_clock_in(ext_ref), .retained_stop_mode_in(stop_mode),
      .core_compare_in(cmp), .core_out(core), .conversion_active_out(active), .irq_out(irq));
   sacc_core_model core_u (.sys_clk_in(sys_clk_in), .core_in(core), .compare_out(cmp));
   // System clock at 250 MHz.
   initial begin
      forever #2 sys_clk_in = ~sys_clk_in;
   end
   // Slow reference clock for the trigger counter, and the hang guard.
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (ext_run && cycles[0]) ext_ref <= ~ext_ref;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   // Read data closes with its data phase; compare it with the oldest note.
   always @(posedge sys_clk_in) begin
      if (rd_flag) check(hrdata, exp_q.pop_front());
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single transfer; the address phase is held until ready is seen.
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge sys_clk_in);
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      haddr_in <= {24'h0, addr};
      hwrite_in <= wr;
      do @(posedge sys_clk_in); while (hready !== 1'b1);
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= data;
      rd_flag <= !wr;
      do @(posedge sys_clk_in); while (hready !== 1'b1);
      rd_flag <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   // Bounded wait for the active level; running out counts as a mismatch.
   task automatic wait_act(input logic lvl, input int lim);
      int i;
      i = 0;
      while (active !== lvl && i < lim) begin
         @(negedge sys_clk_in);
         i++;
      end
      check(32'(active), 32'(lvl));
   endtask
   function automatic logic [9:0] level(input logic [4:0] ch);
      if (ch == sacc_pkg::CH_HIGH_REF) return 10'h3ff;
      if (ch == sacc_pkg::CH_LOW_REF) return 10'h000;
      return {ch, ch};
   endfunction
   // One software conversion with full result, flag and interrupt checks.
   task automatic convert(input logic [4:0] ch, input logic ie, input logic m10);
      logic [9:0] lv;
      lv = level(ch);
      wr(sacc_pkg::OFS_STATUS_CONTROL, {24'h0, 1'b0, ie, 1'b0, ch});
      repeat (2) @(negedge sys_clk_in);
      check(32'(active), 32'h1);
      wait_act(1'b0, 40);
      repeat (2) @(negedge sys_clk_in);
      check(32'(irq), 32'(ie));
      rd(sacc_pkg::OFS_STATUS_CONTROL, {24'h0, 1'b1, ie, 1'b0, ch});
      rd(sacc_pkg::OFS_IRQ_STATUS, 32'h1);
      rd(sacc_pkg::OFS_RESULT_HIGH, m10 ? 32'(lv[9:8]) : 32'h0);
      rd(sacc_pkg::OFS_RESULT_LOW, m10 ? 32'(lv[7:0]) : 32'(lv[9:2]));
      rd(sacc_pkg::OFS_STATUS_CONTROL, {24'h0, 1'b0, ie, 1'b0, ch});
      wr(sacc_pkg::OFS_IRQ_STATUS, 32'h3);
      @(negedge sys_clk_in);
      check(32'(irq | active | core.power_on), 32'h0);
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence; reset is held for three cycles.
   initial begin
      logic [4:0] chs[4];
      chs = '{sacc_pkg::CH_HIGH_REF, sacc_pkg::CH_LOW_REF, 5'h00, sacc_pkg::CH_LAST_PIN};
      void'($urandom(32'h2122187d));
      repeat (3) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      rd(sacc_pkg::OFS_STATUS_CONTROL, 32'h1f);
      rd(8'h40, 32'h0);
      wr(sacc_pkg::OFS_IRQ_MASK, 32'h1);
      wr(sacc_pkg::OFS_CONFIG, 32'h1);
      for (int k = 0; k < 6; k++) begin
         convert((k < 4) ? chs[k] : 5'($urandom_range(27, 0)), k[0], 1'b1);
      end
      wr(sacc_pkg::OFS_CONFIG, 32'h0);
      convert(5'h13, 1'b1, 1'b0);
      wr(sacc_pkg::OFS_CONFIG, 32'h1);
      // A write in mid-conversion restarts on the new channel.
      wr(sacc_pkg::OFS_STATUS_CONTROL, 32'h05);
      repeat (4) @(negedge sys_clk_in);
      convert(5'h06, 1'b0, 1'b1);
      wr(sacc_pkg::OFS_STATUS_CONTROL, 32'h05);
      repeat (4) @(negedge sys_clk_in);
      wr(sacc_pkg::OFS_STATUS_CONTROL, 32'h1f);
      repeat (3) @(negedge sys_clk_in);
      check(32'(active | core.power_on), 32'h0);
      rd(sacc_pkg::OFS_STATUS_CONTROL, 32'h1f);
      // Continuous conversions keep setting the flag until disabled.
      wr(sacc_pkg::OFS_STATUS_CONTROL, 32'h25);
      repeat (60) @(negedge sys_clk_in);
      rd(sacc_pkg::OFS_RESULT_LOW, 32'ha5);
      repeat (30) @(negedge sys_clk_in);
      rd(sacc_pkg::OFS_STATUS_CONTROL, 32'ha5);
      wr(sacc_pkg::OFS_STATUS_CONTROL, 32'h1f);
      repeat (40) @(negedge sys_clk_in);
      rd(sacc_pkg::OFS_STATUS_CONTROL, 32'h1f);
      // Compare below and at-or-above, against both ends of the range.
      for (int k = 0; k < 4; k++) begin
         wr(sacc_pkg::OFS_COMPARE, k[1] ? 32'h3ff : 32'h0);
         wr(sacc_pkg::OFS_STATUS2, k[0] ? 32'h30 : 32'h20);
         wr(sacc_pkg::OFS_STATUS_CONTROL, 32'h05);
         repeat (2) @(negedge sys_clk_in);
         wait_act(1'b0, 40);
         rd(sacc_pkg::OFS_STATUS_CONTROL, {24'h0, k[0] ^ k[1], 7'h05});
      end
      wr(sacc_pkg::OFS_STATUS2, 32'h0);
      wr(sacc_pkg::OFS_IRQ_STATUS, 32'h3);
      // Stop mode blocks a start until both low-voltage bits are set.
      stop_mode <= 1'b1;
      wr(sacc_pkg::OFS_STATUS_CONTROL, 32'h05);
      repeat (4) @(negedge sys_clk_in);
      check(32'(active), 32'h0);
      wr(sacc_pkg::OFS_POWER_MGMT, 32'h3);
      wr(sacc_pkg::OFS_STATUS_CONTROL, 32'h05);
      wait_act(1'b1, 4);
      wait_act(1'b0, 40);
      rd(sacc_pkg::OFS_STATUS_CONTROL, 32'h85);
      stop_mode <= 1'b0;
      wr(sacc_pkg::OFS_IRQ_STATUS, 32'h3);
      // Hardware trigger from the counter on the reference clock.
      wr(sacc_pkg::OFS_CONFIG, 32'h81);
      wr(sacc_pkg::OFS_STATUS2, 32'h40);
      wr(sacc_pkg::OFS_STATUS_CONTROL, 32'h45);
      repeat (8) @(negedge sys_clk_in);
      check(32'(active), 32'h0);
      ext_run <= 1'b1;
      wait_act(1'b1, 3000);
      wait_act(1'b0, 40);
      repeat (2) @(negedge sys_clk_in);
      check(32'(irq), 32'h1);
      rd(sacc_pkg::OFS_STATUS_CONTROL, 32'hc5);
      end_of_test();
   end
endmodule
`default_nettype wire
